// ===== hw/angle_calc_pkg.sv
// Purpose: shared constants and types for the electrical angle timer and waveform unit
// Assumes: 32-bit classic Wishbone, one register per aligned word, byte address = 4 * index
// Notes:   all offsets, field positions and the two control register reset values used by the design live here
package angle_calc_pkg;

  localparam int REG_IDX_W = 14;
  localparam logic [REG_IDX_W-1:0] IDX_ANGLE_TIMER_CONTROL = 14'h1fc0;
  localparam logic [REG_IDX_W-1:0] IDX_CALC_CONTROL        = 14'h1fc1;
  localparam logic [REG_IDX_W-1:0] IDX_ANGLE_PERIOD        = 14'h1fc2;
  localparam logic [REG_IDX_W-1:0] IDX_CURRENT_ANGLE       = 14'h1fc3;
  localparam logic [REG_IDX_W-1:0] IDX_VOLTAGE_AMPLITUDE   = 14'h1fc4;
  localparam logic [REG_IDX_W-1:0] IDX_ANGLE_CAPTURE       = 14'h1fc5;
  localparam logic [REG_IDX_W-1:0] IDX_SINE_TABLE_WRITE    = 14'h1fc6;
  localparam logic [REG_IDX_W-1:0] IDX_RESULT_U            = 14'h1fc7;
  localparam logic [REG_IDX_W-1:0] IDX_RESULT_V            = 14'h1fc8;
  localparam logic [REG_IDX_W-1:0] IDX_RESULT_W            = 14'h1fc9;

  // angle_timer_control fields
  localparam int BIT_COUNT_DIRECTION = 7;
  localparam int BIT_PHASE_ORDER     = 6;
  localparam int BIT_PRESCALE_HI     = 5;
  localparam int BIT_PRESCALE_LO     = 4;
  localparam int BIT_MODULATION      = 3;
  localparam int BIT_XFER_ENABLE     = 2;
  localparam int BIT_CALC_ENABLE     = 1;
  localparam int BIT_TIMER_ENABLE    = 0;
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;

  // calc_control fields
  localparam int BIT_SOFT_START  = 3;
  localparam int BIT_CALC_BUSY   = 2;
  localparam int BIT_SYNC_DIS    = 1;
  localparam int BIT_IRQ_SELECT  = 0;
  localparam logic [1:0] CALC_CONTROL_RESET = 2'h0;

  // angle_period_setting fields
  localparam int PERIOD_HI     = 11;
  localparam int FRACTION_LO   = 12;
  localparam int FRACTION_HI   = 15;
  localparam logic [11:0] PERIOD_MIN = 12'h010;

  localparam logic [8:0] ANGLE_MAX     = 9'h17f;
  localparam logic [8:0] ANGLE_HALF    = 9'h0bf;
  localparam logic [9:0] ANGLE_FULL    = 10'h180;
  localparam logic [9:0] ANGLE_THIRD   = 10'h080;
  localparam logic [9:0] ANGLE_2THIRD  = 10'h100;

  // prescaler masks for fc/8, fc/16, fc/32, fc/64
  localparam logic [5:0] PRESCALE_MASK_8  = 6'h07;
  localparam logic [5:0] PRESCALE_MASK_16 = 6'h0f;
  localparam logic [5:0] PRESCALE_MASK_32 = 6'h1f;
  localparam logic [5:0] PRESCALE_MASK_64 = 6'h3f;

  localparam logic [1:0] PHASE_U = 2'h0;
  localparam logic [1:0] PHASE_V = 2'h1;
  localparam logic [1:0] PHASE_W = 2'h2;

  typedef struct packed {
    logic [15:0] u;
    logic [15:0] v;
    logic [15:0] w;
  } phase_result_t;

  typedef enum logic {CALC_IDLE, CALC_RUN} calc_state_t;

endpackage

// ===== hw/electrical_angle_waveform_calc.sv
// Purpose: electrical angle timer and sine waveform arithmetic unit, Wishbone register slave
// Assumes: one 20 MHz clock; position_detect_i and modulation period come from same-clock logic
// Notes:   one phase is computed per cycle, so a calculation takes three cycles
// Functional notes
// - period field sets prescaled ticks per step
// - correction n lengthens n of 16 steps
// - angle readable, writable while timer runs
// - angle writes above 17FH rejected
// - result is amplitude times table sample
// - amplitude limited by modulation period
// - position detect latches angle into capture
// - software start bit begins calculation
// - busy bit shows calculation in progress
// - sync bit chooses angle-event start
// - interrupt source: period end or calc end
// - direction bit selects angle up or down
// - phase order selects plus/minus 120 offsets
// - prescaler selects fc/8 through fc/64
// - modulation bit selects two or three phase
// - transfer, calculation and timer enable bits
// - period below 010H treated as 010H
// - timer disable stops and clears count
// - software start aborts running calculation
// - three-phase sign depends on half cycle
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
module electrical_angle_waveform_calc
  import angle_calc_pkg::*;
#(
  parameter int SAMPLE_W = 8
) (
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [15:0]         wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output      logic [31:0]         wb_dat_o,
  output      logic                wb_ack_o,
  input  wire logic [15:0]         pwm_modulation_period_i,
  input  wire logic                position_detect_i,
  output      phase_result_t       u_phase_compare_o,
  output      logic                compare_load_o,
  output      logic                angle_irq_o
);

  localparam int ANGLES = 384;

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [1:0] sel);
    merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  function automatic logic [8:0] phase_angle(input logic [8:0] base, input logic [1:0] k,
                                             input logic rev);
    logic [9:0] off;
    logic [10:0] s;
    off = (k == PHASE_V) ? ANGLE_THIRD : (k == PHASE_W) ? ANGLE_2THIRD : 10'h000;
    s = rev ? ({2'b00, base} + {1'b0, ANGLE_FULL} - {1'b0, off}) : ({2'b00, base} + {1'b0, off});
    if (s >= {1'b0, ANGLE_FULL}) begin
      s = s - {1'b0, ANGLE_FULL};
    end
    phase_angle = s[8:0];
  endfunction

  // ---------------- register bus ----------------
  logic                 ack_q;
  logic [31:0]          rdata_q;
  logic [7:0]           timer_ctrl_q;
  logic [1:0]           calc_ctrl_q;
  logic [15:0]          period_set_q;
  logic [8:0]           current_angle_q;
  logic [8:0]           current_angle_d;
  logic [15:0]          amplitude_q;
  logic [8:0]           angle_capture_q;
  logic [SAMPLE_W-1:0]  sine_table_q [ANGLES];

  wire logic [REG_IDX_W-1:0] bus_idx = wb_adr_i[15:2];
  wire logic bus_req  = wb_cyc_i && wb_stb_i;
  // writes land on the ack edge, where the master samples the answer
  wire logic bus_wr   = bus_req && wb_we_i && ack_q;
  wire logic [15:0] wlo = wb_dat_i[15:0];

  wire logic wr_timer_ctrl = bus_wr && bus_idx == IDX_ANGLE_TIMER_CONTROL && wb_sel_i[0];
  wire logic wr_calc_ctrl  = bus_wr && bus_idx == IDX_CALC_CONTROL && wb_sel_i[0];
  wire logic wr_period     = bus_wr && bus_idx == IDX_ANGLE_PERIOD;
  wire logic wr_angle      = bus_wr && bus_idx == IDX_CURRENT_ANGLE;
  wire logic wr_amplitude  = bus_wr && bus_idx == IDX_VOLTAGE_AMPLITUDE;
  wire logic wr_table      = bus_wr && bus_idx == IDX_SINE_TABLE_WRITE;

  wire logic [15:0] angle_wval = merge16({7'h00, current_angle_q}, wlo, wb_sel_i[1:0]);
  wire logic angle_wr_ok = wr_angle && (angle_wval[8:0] <= ANGLE_MAX) && (angle_wval[15:9] == 7'h00);

  wire logic count_down   = timer_ctrl_q[BIT_COUNT_DIRECTION];
  wire logic phase_rev    = timer_ctrl_q[BIT_PHASE_ORDER];
  wire logic [1:0] presc_sel = timer_ctrl_q[BIT_PRESCALE_HI:BIT_PRESCALE_LO];
  wire logic three_phase  = timer_ctrl_q[BIT_MODULATION];
  wire logic xfer_en      = timer_ctrl_q[BIT_XFER_ENABLE];
  wire logic calc_en      = timer_ctrl_q[BIT_CALC_ENABLE];
  wire logic timer_en     = timer_ctrl_q[BIT_TIMER_ENABLE];
  wire logic sync_dis     = calc_ctrl_q[BIT_SYNC_DIS];
  wire logic irq_sel      = calc_ctrl_q[BIT_IRQ_SELECT];
  wire logic soft_start   = wr_calc_ctrl && wb_dat_i[BIT_SOFT_START];

  calc_state_t   state_q;
  phase_result_t result_q;
  phase_result_t cmp_q;

  wire logic busy = (state_q == CALC_RUN);
  wire logic [7:0] calc_ctrl_rd = {4'h0, 1'b0, busy, calc_ctrl_q};

  wire logic [15:0] rd_mux =
    (bus_idx == IDX_ANGLE_TIMER_CONTROL) ? {8'h00, timer_ctrl_q} :
    (bus_idx == IDX_CALC_CONTROL)        ? {8'h00, calc_ctrl_rd} :
    (bus_idx == IDX_ANGLE_PERIOD)        ? period_set_q :
    (bus_idx == IDX_CURRENT_ANGLE)       ? {7'h00, current_angle_q} :
    (bus_idx == IDX_VOLTAGE_AMPLITUDE)   ? amplitude_q :
    (bus_idx == IDX_ANGLE_CAPTURE)       ? {7'h00, angle_capture_q} :
    (bus_idx == IDX_RESULT_U)            ? result_q.u :
    (bus_idx == IDX_RESULT_V)            ? result_q.v :
    (bus_idx == IDX_RESULT_W)            ? result_q.w : 16'h0000;

  // unmapped and write-only words answer with zero so a stray read never hangs the master
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= bus_req && !ack_q;
      rdata_q <= (bus_req && !ack_q && !wb_we_i) ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // plain register writes; calc_control keeps only its two stored bits
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      timer_ctrl_q <= TIMER_CONTROL_RESET;
      calc_ctrl_q  <= CALC_CONTROL_RESET;
      period_set_q <= 16'h0000;
      amplitude_q  <= 16'h0000;
    end else begin
      if (wr_timer_ctrl) begin
        timer_ctrl_q <= wb_dat_i[7:0];
      end
      if (wr_calc_ctrl) begin
        calc_ctrl_q <= wb_dat_i[BIT_SYNC_DIS:BIT_IRQ_SELECT];
      end
      if (wr_period) begin
        period_set_q <= merge16(period_set_q, wlo, wb_sel_i[1:0]);
      end
      if (wr_amplitude) begin
        amplitude_q <= merge16(amplitude_q, wlo, wb_sel_i[1:0]);
      end
    end
  end

  // table entry addressed by the current angle; not reset, contents are software's
  always_ff @(posedge clk_i) begin
    if (wr_table) begin
      sine_table_q[current_angle_q] <= wlo[SAMPLE_W-1:0];
    end
  end

  // ---------------- electrical angle timer ----------------
  logic [5:0]  presc_q;
  logic [12:0] step_cnt_q;
  logic [3:0]  group_q;

  wire logic [5:0] presc_mask =
    (presc_sel == 2'b00) ? PRESCALE_MASK_8 :
    (presc_sel == 2'b01) ? PRESCALE_MASK_16 :
    (presc_sel == 2'b10) ? PRESCALE_MASK_32 : PRESCALE_MASK_64;
  wire logic tick = timer_en && ((presc_q & presc_mask) == presc_mask);

  wire logic [11:0] period_raw = period_set_q[PERIOD_HI:0];
  wire logic [11:0] period_m   = (period_raw < PERIOD_MIN) ? PERIOD_MIN : period_raw;
  wire logic [3:0]  fraction_n = period_set_q[FRACTION_HI:FRACTION_LO];
  wire logic        extend     = (group_q < fraction_n);
  wire logic [12:0] step_last  = {1'b0, period_m} + {12'h000, extend} - 13'h0001;
  wire logic        period_done = tick && (step_cnt_q == step_last);

  wire logic [8:0] angle_step =
    count_down ? ((current_angle_q == 9'h000) ? ANGLE_MAX : current_angle_q - 9'h001) :
                 ((current_angle_q == ANGLE_MAX) ? 9'h000 : current_angle_q + 9'h001);

  // a software write overrides a step landing in the same cycle
  assign current_angle_d = angle_wr_ok ? angle_wval[8:0] :
                           period_done ? angle_step : current_angle_q;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !timer_en) begin
      presc_q    <= 6'h00;
      step_cnt_q <= 13'h0000;
      group_q    <= 4'h0;
    end else begin
      presc_q <= presc_q + 6'h01;
      if (period_done) begin
        step_cnt_q <= 13'h0000;
        group_q    <= group_q + 4'h1;
      end else if (tick) begin
        step_cnt_q <= step_cnt_q + 13'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      current_angle_q <= 9'h000;
      angle_capture_q <= 9'h000;
    end else begin
      current_angle_q <= current_angle_d;
      if (position_detect_i) begin
        angle_capture_q <= current_angle_q;
      end
    end
  end

  // ---------------- waveform arithmetic ----------------
  logic [1:0] phase_q;
  logic       calc_done_q;
  logic       compare_load_q;
  logic       irq_q;

  wire logic sync_event = !sync_dis && (period_done || angle_wr_ok);
  wire logic calc_start = calc_en && (soft_start || sync_event);

  wire logic [8:0] ph_angle = phase_angle(current_angle_q, phase_q, phase_rev);
  wire logic [SAMPLE_W-1:0] sample = sine_table_q[ph_angle];
  wire logic [15:0] ampl_eff = (amplitude_q > pwm_modulation_period_i) ?
                               pwm_modulation_period_i : amplitude_q;
  wire logic [15+SAMPLE_W:0] product = ampl_eff * sample;
  wire logic [15:0] scaled  = product[15+SAMPLE_W:SAMPLE_W];
  wire logic [15:0] half_md = {1'b0, pwm_modulation_period_i[15:1]};
  wire logic [15:0] half_sc = {1'b0, scaled[15:1]};
  wire logic [15:0] phase_res = !three_phase ? scaled :
                                (ph_angle <= ANGLE_HALF) ? half_md + half_sc : half_md - half_sc;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_q     <= CALC_IDLE;
      phase_q     <= PHASE_U;
      calc_done_q <= 1'b0;
      result_q    <= '0;
    end else begin
      calc_done_q <= 1'b0;
      if (!calc_en) begin
        state_q <= CALC_IDLE;
      end else if (calc_start) begin
        state_q <= CALC_RUN;
        phase_q <= PHASE_U;
      end else begin
        case (state_q)
          CALC_IDLE: begin
            phase_q <= PHASE_U;
          end
          CALC_RUN: begin
            case (phase_q)
              PHASE_U: result_q.u <= phase_res;
              PHASE_V: result_q.v <= phase_res;
              default: result_q.w <= phase_res;
            endcase
            if (phase_q == PHASE_W) begin
              state_q     <= CALC_IDLE;
              calc_done_q <= 1'b1;
            end else begin
              phase_q <= phase_q + 2'h1;
            end
          end
          default: begin
            state_q <= CALC_IDLE;
          end
        endcase
      end
    end
  end

  // compare values follow only whole calculations, never a half-written set
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cmp_q          <= '0;
      compare_load_q <= 1'b0;
      irq_q          <= 1'b0;
    end else begin
      compare_load_q <= calc_done_q && xfer_en && calc_en;
      if (calc_done_q && xfer_en && calc_en) begin
        cmp_q <= result_q;
      end
      irq_q <= irq_sel ? calc_done_q : period_done;
    end
  end
  assign u_phase_compare_o = cmp_q;
  assign compare_load_o    = compare_load_q;
  assign angle_irq_o       = irq_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_angle_in_range: assert property (current_angle_q <= ANGLE_MAX)
    else $error("angle above highest index");
  a_timer_cleared: assert property (!timer_en |=> step_cnt_q == 13'h0000 && !period_done)
    else $error("disabled timer kept counting");
  a_period_floor: assert property (period_done |-> step_cnt_q >= {1'b0, PERIOD_MIN} - 13'h0001)
    else $error("period shorter than minimum");
  // a software angle write wins over a step, so the counting checks leave it out
  a_wrap_up: assert property (period_done && !count_down && !angle_wr_ok &&
                              current_angle_q == ANGLE_MAX |=> current_angle_q == 9'h000)
    else $error("up count did not wrap to zero");
  a_wrap_down: assert property (period_done && count_down && !angle_wr_ok &&
                                current_angle_q == 9'h000 |=> current_angle_q == ANGLE_MAX)
    else $error("down count did not wrap to top");
  a_step_up: assert property (period_done && !count_down && !angle_wr_ok &&
                              current_angle_q != ANGLE_MAX |=>
                              current_angle_q == $past(current_angle_q) + 9'h001)
    else $error("angle did not count up");
  a_step_down: assert property (period_done && count_down && !angle_wr_ok &&
                                current_angle_q != 9'h000 |=>
                                current_angle_q == $past(current_angle_q) - 9'h001)
    else $error("angle did not count down");
  a_angle_load: assert property (angle_wr_ok |=>
                                 current_angle_q == $past(angle_wval[8:0]))
    else $error("angle write lost");
  a_angle_reject: assert property (wr_angle && !angle_wr_ok && !period_done |=>
                                   $stable(current_angle_q))
    else $error("out of range angle accepted");
  // a tick needs the low three prescaler bits set, so ticks never come closer than eight
  a_tick_spacing: assert property (tick |=> !tick[*7])
    else $error("prescaled tick too frequent");
  a_capture_angle: assert property (position_detect_i |=>
                                    angle_capture_q == $past(current_angle_q))
    else $error("capture missed angle");
  a_soft_start_busy: assert property (soft_start && calc_en |=> busy && phase_q == PHASE_U)
    else $error("software start ignored");
  a_sync_start: assert property (period_done && !sync_dis && calc_en |=> busy)
    else $error("angle event did not start calculation");
  a_calc_length: assert property (calc_start ##1
                                  (busy && calc_en && !calc_start)[*3] |=> !busy)
    else $error("calculation length wrong");
  a_result_idle: assert property (!busy && !calc_start |=> $stable(result_q))
    else $error("results changed while stopped");
  a_calc_off: assert property (!calc_en |=> !busy)
    else $error("calculation ran while disabled");
  a_irq_period: assert property (!irq_sel && period_done |=> angle_irq_o)
    else $error("period interrupt missing");
  a_irq_calc: assert property (irq_sel && calc_done_q |=> angle_irq_o)
    else $error("calculation interrupt missing");
  a_ampl_limit: assert property (ampl_eff <= pwm_modulation_period_i)
    else $error("amplitude above modulation period");
  a_transfer_load: assert property (calc_done_q && xfer_en && calc_en |=>
                                    compare_load_o && u_phase_compare_o == $past(result_q))
    else $error("results not transferred");
  // the pwm side may sample compare values at any time, so they only move on a load
  a_compare_hold: assert property (!compare_load_o |-> $stable(u_phase_compare_o))
    else $error("compare values changed without load");
  a_busy_flag: assert property (bus_req && !ack_q && !wb_we_i &&
                                bus_idx == IDX_CALC_CONTROL |=>
                                wb_dat_o[BIT_CALC_BUSY] == $past(busy))
    else $error("busy bit not shown");

  c_calc_done: cover property (calc_done_q && xfer_en);
  c_abort: cover property (busy && soft_start && calc_en);
  c_wrap: cover property (period_done && current_angle_q == ANGLE_MAX);
  c_capture: cover property (position_detect_i && timer_en);
  c_three_phase: cover property (busy && three_phase && phase_rev);

endmodule

// ===== bench/pwm_posdet_model.sv
// Purpose: far-side model of the pwm generator and the position detection logic
// Assumes: same clock as the block; detect and seen outputs are registered like the real logic, mod_period_o is a constant
// Notes:   modulation period is a fixed level; detect pulses only when the bench asks
`timescale 1ns/1ns
module pwm_posdet_model
  import angle_calc_pkg::*;
#(
  parameter logic [15:0] MOD_PERIOD = 16'h0200
) (
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire phase_result_t cmp_i,
  input  wire logic          load_i,
  input  wire logic          detect_req_i,
  output      logic [15:0]   mod_period_o,
  output      logic          detect_o,
  output      phase_result_t seen_o
);
  assign mod_period_o = MOD_PERIOD;

  // compare values are taken only on the load pulse, as the pwm side would
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      detect_o <= 1'b0;
      seen_o   <= '0;
    end else begin
      detect_o <= detect_req_i;
      if (load_i) begin
        seen_o <= cmp_i;
      end
    end
  end
endmodule

// ===== bench/electrical_angle_waveform_calc_tb.sv
// Purpose: self-checking bench for the angle timer and waveform unit
// Assumes: wishbone answers with ack in the second cycle of a request
// Notes:   step lengths are measured between period interrupts
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
  n_checks++; \
  if ((got) !== (ex)) begin \
    err_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
  end \
end
module electrical_angle_waveform_calc_tb
  import angle_calc_pkg::*;
();
  localparam logic [15:0] MOD_PERIOD = 16'h0200;
  logic          clk_i      = 1'b0;
  logic          rst_b_i    = 1'b0;
  logic          wb_cyc     = 1'b0;
  logic          wb_stb     = 1'b0;
  logic          wb_we      = 1'b0;
  logic [15:0]   wb_adr     = 16'h0000;
  logic [3:0]    wb_sel     = 4'h0;
  logic [31:0]   wb_wdat    = 32'h0000_0000;
  logic [31:0]   wb_rdat;
  logic          wb_ack;
  logic [15:0]   mod_period;
  logic          detect;
  logic          detect_req = 1'b0;
  phase_result_t cmp;
  phase_result_t seen;
  logic          load;
  logic          irq;
  int            err_count  = 0;
  int            n_checks   = 0;

  electrical_angle_waveform_calc u_electrical_angle_waveform_calc (
    .clk_i                   (clk_i),
    .rst_b_i                 (rst_b_i),
    .wb_cyc_i                (wb_cyc),
    .wb_stb_i                (wb_stb),
    .wb_we_i                 (wb_we),
    .wb_adr_i                (wb_adr),
    .wb_sel_i                (wb_sel),
    .wb_dat_i                (wb_wdat),
    .wb_dat_o                (wb_rdat),
    .wb_ack_o                (wb_ack),
    .pwm_modulation_period_i (mod_period),
    .position_detect_i       (detect),
    .u_phase_compare_o       (cmp),
    .compare_load_o          (load),
    .angle_irq_o             (irq)
  );

  pwm_posdet_model #(.MOD_PERIOD(MOD_PERIOD)) u_pwm_posdet_model (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .cmp_i        (cmp),
    .load_i       (load),
    .detect_req_i (detect_req),
    .mod_period_o (mod_period),
    .detect_o     (detect),
    .seen_o       (seen)
  );

  always #25 clk_i = ~clk_i;

  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one classic cycle; only the watchdog ends the wait for a dead slave
  task automatic bus(input logic w, input logic [13:0] idx, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= {idx, 2'b00};
    wb_sel  <= 4'h3;
    wb_wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_rdat[15:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [13:0] idx, input logic [15:0] ex);
    logic [15:0] q;
    bus(1'b0, idx, 16'h0000, q);
    `CHK(nm, ex, q)
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (irq !== 1'b1 && n < 3000);
    if (n >= 3000) err_count++;
  endtask

  task automatic wait_load(output int n, output logic iq);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (load !== 1'b1 && n < 20);
    iq = irq;
  endtask

  function automatic int tbl(int i);
    return ((i * 5) >> 1) & 255;
  endfunction

  function automatic logic [15:0] expv(int idx, logic [15:0] ampl, logic three);
    int ae;
    int sc;
    ae = (ampl > MOD_PERIOD) ? MOD_PERIOD : ampl;
    sc = (ae * tbl(idx)) >> 8;
    if (!three) return 16'(sc);
    return (idx <= 191) ? 16'(MOD_PERIOD / 2 + sc / 2) : 16'(MOD_PERIOD / 2 - sc / 2);
  endfunction

  task automatic t_reset();
    rd_chk("timer ctrl", IDX_ANGLE_TIMER_CONTROL, 16'h0000);
    rd_chk("calc ctrl", IDX_CALC_CONTROL, 16'h0000);
    rd_chk("unmapped", 14'h1fca, 16'h0000);
    rd_chk("table read", IDX_SINE_TABLE_WRITE, 16'h0000);
    wr(IDX_CALC_CONTROL, 16'h0003);
    rd_chk("calc ctrl rw", IDX_CALC_CONTROL, 16'h0003);
    wr(IDX_CALC_CONTROL, 16'h0000);
  endtask

  task automatic t_angle_capture();
    wr(IDX_CURRENT_ANGLE, 16'h017f);
    rd_chk("angle", IDX_CURRENT_ANGLE, 16'h017f);
    wr(IDX_CURRENT_ANGLE, 16'h0180);
    rd_chk("angle over", IDX_CURRENT_ANGLE, 16'h017f);
    wr(IDX_CURRENT_ANGLE, 16'h0055);
    wr(IDX_ANGLE_CAPTURE, 16'h0012);
    rd_chk("capture ro", IDX_ANGLE_CAPTURE, 16'h0000);
    @(posedge clk_i);
    detect_req <= 1'b1;
    @(posedge clk_i);
    detect_req <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd_chk("capture", IDX_ANGLE_CAPTURE, 16'h0055);
  endtask

  // sum of several step lengths; over sixteen steps the correction pattern is complete
  task automatic t_step(input logic [1:0] p, input logic [15:0] per, input int steps,
                        input int ex);
    int n;
    int sum = 0;
    wr(IDX_ANGLE_TIMER_CONTROL, {10'h000, p, 4'h0});
    wr(IDX_ANGLE_PERIOD, per);
    wr(IDX_ANGLE_TIMER_CONTROL, {10'h000, p, 4'h1});
    wait_irq(n);
    repeat (steps) begin
      wait_irq(n);
      sum += n;
    end
    wr(IDX_ANGLE_TIMER_CONTROL, {10'h000, p, 4'h0});
    `CHK("step cycles", ex, sum)
  endtask

  task automatic t_wrap(input logic [7:0] ctl, input logic [15:0] a0, input logic [15:0] a1);
    int n;
    wr(IDX_ANGLE_TIMER_CONTROL, 16'h0000);
    wr(IDX_ANGLE_PERIOD, 16'h0010);
    wr(IDX_CURRENT_ANGLE, a0);
    wr(IDX_ANGLE_TIMER_CONTROL, {8'h00, ctl});
    wait_irq(n);
    rd_chk("stepped angle", IDX_CURRENT_ANGLE, a1);
    wr(IDX_ANGLE_TIMER_CONTROL, 16'h0000);
  endtask

  // a restart after disable must take a full step, not the remainder
  task automatic t_clear();
    int n;
    wr(IDX_ANGLE_TIMER_CONTROL, 16'h0001);
    repeat (100) @(posedge clk_i);
    wr(IDX_ANGLE_TIMER_CONTROL, 16'h0000);
    wr(IDX_ANGLE_TIMER_CONTROL, 16'h0001);
    wait_irq(n);
    `CHK("full step after clear", 1'b1, n >= 120)
    wr(IDX_ANGLE_TIMER_CONTROL, 16'h0000);
  endtask

  task automatic t_table();
    wr(IDX_ANGLE_TIMER_CONTROL, 16'h0000);
    for (int i = 0; i < 384; i++) begin
      wr(IDX_CURRENT_ANGLE, 16'(i));
      wr(IDX_SINE_TABLE_WRITE, 16'(tbl(i)));
    end
  endtask

  task automatic t_calc(input logic [7:0] ctl, input logic [15:0] ampl, input int a,
                        input logic [7:0] cc);
    int n;
    logic iq;
    int v;
    int w;
    phase_result_t e;
    v = ctl[6] ? (a + 256) % 384 : (a + 128) % 384;
    w = ctl[6] ? (a + 128) % 384 : (a + 256) % 384;
    e = {expv(a, ampl, ctl[3]), expv(v, ampl, ctl[3]), expv(w, ampl, ctl[3])};
    wr(IDX_VOLTAGE_AMPLITUDE, ampl);
    wr(IDX_CURRENT_ANGLE, 16'(a));
    wr(IDX_ANGLE_TIMER_CONTROL, {8'h00, ctl});
    wr(IDX_CALC_CONTROL, {8'h00, cc});
    wait_load(n, iq);
    if (ctl[2]) begin
      `CHK("compare out", e, cmp)
      `CHK("calc irq", cc[0], iq)
    end
    rd_chk("result u", IDX_RESULT_U, e.u);
    rd_chk("result v", IDX_RESULT_V, e.v);
    rd_chk("result w", IDX_RESULT_W, e.w);
    if (ctl[2]) `CHK("pwm side", e, seen)
  endtask

  task automatic t_sync();
    int n;
    logic iq;
    wr(IDX_ANGLE_TIMER_CONTROL, 16'h0006);
    wr(IDX_CALC_CONTROL, 16'h0002);
    wait_load(n, iq);
    `CHK("no start on zero", 1'b1, n >= 20)
    wr(IDX_CURRENT_ANGLE, 16'h0033);
    wait_load(n, iq);
    `CHK("no sync start", 1'b1, n >= 20)
    wr(IDX_CALC_CONTROL, 16'h0000);
    wr(IDX_CURRENT_ANGLE, 16'h0034);
    wait_load(n, iq);
    `CHK("sync start", 1'b1, n < 20)
    rd_chk("busy idle", IDX_CALC_CONTROL, 16'h0000);
    wr(IDX_CURRENT_ANGLE, 16'h0035);
    wr(IDX_CALC_CONTROL, 16'h0008);
    wait_load(n, iq);
    `CHK("abort restart", 5, n)
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_angle_capture();
    for (int p = 0; p < 4; p++) begin
      t_step(2'(p), 16'h0010, 1, 128 << p);
    end
    t_step(2'h0, 16'h0005, 1, 128);
    t_step(2'h0, 16'h0020, 2, 512);
    t_step(2'h0, 16'h3010, 16, 2072);
    t_wrap(8'h01, 16'h017f, 16'h0000);
    t_wrap(8'h81, 16'h0000, 16'h017f);
    t_wrap(8'h81, 16'h0100, 16'h00ff);
    t_clear();
    t_table();
    t_calc(8'h02, 16'h0100, 16, 8'h0a);
    t_calc(8'h46, 16'hffff, 16, 8'h0b);
    t_calc(8'h0a, 16'h0180, 192, 8'h0a);
    t_calc(8'h4e, 16'h0100, 191, 8'h0b);
    t_sync();
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    tally_and_finish();
  end
endmodule
